// ### src/sds_map.svh
`ifndef SDS_MAP_SVH
`define SDS_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define SDS_IDX_FIRST_SPREAD_LO 6'd15
`define SDS_IDX_FIRST_SPREAD_HI 6'd16
`define SDS_IDX_THIRD_DIV_HI    6'd17
`define SDS_IDX_THIRD_VCO_LO    6'd18
`define SDS_IDX_THIRD_SPREAD_LO 6'd19
`define SDS_IDX_THIRD_SPREAD_HI 6'd20
`define SDS_IDX_OVERRIDE_EN     6'd21
`define SDS_IDX_CPU_DIV_HI      6'd22
`define SDS_IDX_CPU_VCO_LO      6'd23
`define SDS_IDX_RSVD_FIRST      6'd24
`define SDS_IDX_RSVD_LAST       6'd62
`define SDS_IDX_SPECIAL_POWER   6'd63

// Reset values of the register bytes.
`define SDS_RST_BYTE            8'h00
`define SDS_RST_OVERRIDE_EN     8'h00
`define SDS_RST_SPECIAL_POWER   8'h01

// Field positions.
`define SDS_BIT_CPU_OVERRIDE    1
`define SDS_BIT_SREF_OVERRIDE   0
`define SDS_BIT_STORAGE_PM      1
`define SDS_BIT_XTAL_KEEP       0
`define SDS_REF_DIV_MSB         5

`endif

// ### src/sds_pkg.sv
package sds_pkg;

	// Start-up sequence: two cycles for the strap synchroniser, one load, then service.
	typedef enum logic [3:0] {
		ST_SYNC_A = 4'b0001,
		ST_SYNC_B = 4'b0010,
		ST_LOAD   = 4'b0100,
		ST_RUN    = 4'b1000
	} sds_phase_t;

	// Settings handed to the synthesizers.
	typedef struct packed {
		logic [14:0] first_spread_pct_code;
		logic [5:0]  third_ref_div;
		logic [9:0]  third_vco_div;
		logic [14:0] third_spread_pct_code;
		logic        cpu_override_en;
		logic        serial_ref_override_en;
		logic [5:0]  cpu_ref_div;
		logic [9:0]  cpu_vco_div;
		logic        storage_link_synth_pm;
		logic        crystal_powerdown_keepalive;
	} sds_synth_cfg_t;

	// The register bytes as software sees them.
	typedef struct packed {
		logic [7:0] first_spread_lo;
		logic [7:0] first_spread_hi;
		logic [7:0] third_div_hi;
		logic [7:0] third_vco_lo;
		logic [7:0] third_spread_lo;
		logic [7:0] third_spread_hi;
		logic [7:0] override_en;
		logic [7:0] cpu_div_hi;
		logic [7:0] cpu_vco_lo;
		logic [7:0] special_power;
	} sds_bank_t;

	// Whole state of the register block.
	typedef struct packed {
		sds_phase_t     phase;
		logic [2:0]     fs_meta;
		logic [2:0]     fs_sync;
		sds_bank_t      bank;
		logic           apply;
		logic           pready;
		logic           pslverr;
		logic [31:0]    prdata;
		sds_synth_cfg_t cfg;
	} sds_state_t;

endpackage

// ### src/sds_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "sds_map.svh"

module sds_regs #(
	parameter logic [47:0] ROM_REF_DIV        = {8{6'h0e}},
	parameter logic [79:0] ROM_VCO_DIV        = {8{10'h0c8}},
	parameter logic        STORAGE_PM_DEFAULT = 1'b0
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [2:0]             fs_sel,
	output sds_pkg::sds_synth_cfg_t     synth_cfg
);
	import sds_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Fifteen-bit spread code from its lower and upper byte; bit 7 of the upper is reserved.
	function automatic logic [14:0] spread_of(input logic [7:0] hi, input logic [7:0] lo);
		spread_of = {hi[6:0], lo};
	endfunction

	// Ten-bit VCO divider; the high byte carries bit 8 in bit 7 and bit 9 in bit 6.
	function automatic logic [9:0] vco_of(input logic [7:0] hi, input logic [7:0] lo);
		vco_of = {hi[6], hi[7], lo};
	endfunction

	// High divider byte from a VCO divider and a reference divider.
	function automatic logic [7:0] div_hi_of(input logic [9:0] n, input logic [5:0] m);
		div_hi_of = {n[8], n[9], m};
	endfunction

	// Reference divider of the table row picked by the straps.
	function automatic logic [5:0] rom_ref(input logic [2:0] fs);
		rom_ref = ROM_REF_DIV[fs*6 +: 6];
	endfunction

	// VCO divider of the table row picked by the straps.
	function automatic logic [9:0] rom_vco(input logic [2:0] fs);
		rom_vco = ROM_VCO_DIV[fs*10 +: 10];
	endfunction

	// Synthesizer settings assembled from the register bytes.
	function automatic sds_synth_cfg_t cfg_of(input sds_bank_t b);
		sds_synth_cfg_t c;
		c.first_spread_pct_code       = spread_of(b.first_spread_hi, b.first_spread_lo);
		c.third_ref_div               = b.third_div_hi[`SDS_REF_DIV_MSB:0];
		c.third_vco_div               = vco_of(b.third_div_hi, b.third_vco_lo);
		c.third_spread_pct_code       = spread_of(b.third_spread_hi, b.third_spread_lo);
		c.cpu_override_en             = b.override_en[`SDS_BIT_CPU_OVERRIDE];
		c.serial_ref_override_en      = b.override_en[`SDS_BIT_SREF_OVERRIDE];
		c.cpu_ref_div                 = b.cpu_div_hi[`SDS_REF_DIV_MSB:0];
		c.cpu_vco_div                 = vco_of(b.cpu_div_hi, b.cpu_vco_lo);
		c.storage_link_synth_pm       = b.special_power[`SDS_BIT_STORAGE_PM];
		c.crystal_powerdown_keepalive = b.special_power[`SDS_BIT_XTAL_KEEP];
		cfg_of = c;
	endfunction

	// True for an index that holds a register byte or the empty reserved range.
	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx >= `SDS_IDX_FIRST_SPREAD_LO);
	endfunction

	// Read value of one byte; the reserved range and unmapped indices read zero.
	function automatic logic [7:0] read_byte(input sds_bank_t b, input logic [5:0] idx);
		case (idx)
			`SDS_IDX_FIRST_SPREAD_LO: read_byte = b.first_spread_lo;
			`SDS_IDX_FIRST_SPREAD_HI: read_byte = b.first_spread_hi;
			`SDS_IDX_THIRD_DIV_HI:    read_byte = b.third_div_hi;
			`SDS_IDX_THIRD_VCO_LO:    read_byte = b.third_vco_lo;
			`SDS_IDX_THIRD_SPREAD_LO: read_byte = b.third_spread_lo;
			`SDS_IDX_THIRD_SPREAD_HI: read_byte = b.third_spread_hi;
			`SDS_IDX_OVERRIDE_EN:     read_byte = b.override_en;
			`SDS_IDX_CPU_DIV_HI:      read_byte = b.cpu_div_hi;
			`SDS_IDX_CPU_VCO_LO:      read_byte = b.cpu_vco_lo;
			`SDS_IDX_SPECIAL_POWER:   read_byte = b.special_power;
			default:                  read_byte = 8'h00;
		endcase
	endfunction

	// Bank after writing one byte; indices without storage leave it unchanged.
	function automatic sds_bank_t write_byte(input sds_bank_t b, input logic [5:0] idx,
			input logic [7:0] d);
		sds_bank_t n;
		n = b;
		case (idx)
			`SDS_IDX_FIRST_SPREAD_LO: n.first_spread_lo = d;
			`SDS_IDX_FIRST_SPREAD_HI: n.first_spread_hi = d;
			`SDS_IDX_THIRD_DIV_HI:    n.third_div_hi    = d;
			`SDS_IDX_THIRD_VCO_LO:    n.third_vco_lo    = d;
			`SDS_IDX_THIRD_SPREAD_LO: n.third_spread_lo = d;
			`SDS_IDX_THIRD_SPREAD_HI: n.third_spread_hi = d;
			`SDS_IDX_OVERRIDE_EN:     n.override_en     = d;
			`SDS_IDX_CPU_DIV_HI:      n.cpu_div_hi      = d;
			`SDS_IDX_CPU_VCO_LO:      n.cpu_vco_lo      = d;
			`SDS_IDX_SPECIAL_POWER:   n.special_power   = d;
			default:                  n = b;
		endcase
		write_byte = n;
	endfunction

	// ****************************************************************
	// Reset values
	// ****************************************************************

	localparam logic [7:0] SPECIAL_RST = `SDS_RST_SPECIAL_POWER |
		{6'h00, STORAGE_PM_DEFAULT, 1'b0};
	localparam sds_bank_t BANK_RST = '{
		first_spread_lo: `SDS_RST_BYTE,
		first_spread_hi: `SDS_RST_BYTE,
		third_div_hi:    `SDS_RST_BYTE,
		third_vco_lo:    `SDS_RST_BYTE,
		third_spread_lo: `SDS_RST_BYTE,
		third_spread_hi: `SDS_RST_BYTE,
		override_en:     `SDS_RST_OVERRIDE_EN,
		cpu_div_hi:      `SDS_RST_BYTE,
		cpu_vco_lo:      `SDS_RST_BYTE,
		special_power:   SPECIAL_RST
	};
	// Settings seen by the synthesizers while reset is held.
	localparam sds_synth_cfg_t CFG_RST = cfg_of(BANK_RST);

	// ****************************************************************
	// State
	// ****************************************************************

	sds_state_t s_q;
	sds_state_t s_d;
	logic [5:0] idx;
	logic       commit;

	// The two low address bits are ignored; every register is one aligned word.
	assign idx    = paddr[7:2];
	assign commit = psel && penable && s_q.pready;

	// Table row picked by the synchronised straps; only the load step uses it.
	logic [5:0] row_ref;
	logic [9:0] row_vco;
	assign row_ref = rom_ref(s_q.fs_sync);
	assign row_vco = rom_vco(s_q.fs_sync);

	// Next-state logic for the start-up sequence, the bus and the settings.
	always_comb begin
		s_d         = s_q;
		s_d.fs_meta = fs_sel;
		s_d.fs_sync = s_q.fs_meta;
		s_d.apply   = 1'b0;
		s_d.pready  = 1'b0;
		case (s_q.phase)
			ST_SYNC_A: begin
				s_d.phase = ST_SYNC_B;
			end
			ST_SYNC_B: begin
				s_d.phase = ST_LOAD;
			end
			ST_LOAD: begin
				s_d.phase             = ST_RUN;
				s_d.bank.third_div_hi = div_hi_of(row_vco, row_ref);
				s_d.bank.third_vco_lo = row_vco[7:0];
				s_d.bank.cpu_div_hi   = div_hi_of(row_vco, row_ref);
				s_d.bank.cpu_vco_lo   = row_vco[7:0];
				s_d.cfg               = cfg_of(s_d.bank);
			end
			ST_RUN: begin
				s_d.phase = ST_RUN;
			end
			default: begin
				s_d.phase = ST_SYNC_A;
			end
		endcase
		// The bus is stalled until the straps are loaded, so software never
		// reads a divider byte that is about to be overwritten.
		if (psel && !s_q.pready && s_q.phase == ST_RUN) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = {24'h000000, read_byte(s_q.bank, idx)};
			s_d.pslverr = !mapped(idx);
		end
		if (commit && pwrite) begin
			s_d.bank  = write_byte(s_q.bank, idx, pwdata[7:0]);
			s_d.apply = 1'b1;
		end
		if (s_q.apply) begin
			s_d.cfg = cfg_of(s_q.bank);
		end
	end

	// State register; every field takes a constant under reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.phase   <= ST_SYNC_A;
			s_q.fs_meta <= 3'h0;
			s_q.fs_sync <= 3'h0;
			s_q.bank    <= BANK_RST;
			s_q.apply   <= 1'b0;
			s_q.pready  <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.prdata  <= 32'h00000000;
			s_q.cfg     <= CFG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register.
	assign prdata    = s_q.prdata;
	assign pready    = s_q.pready;
	assign pslverr   = s_q.pslverr;
	assign synth_cfg = s_q.cfg;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rsvd_idx;
	assign rsvd_idx = (idx >= `SDS_IDX_RSVD_FIRST) && (idx <= `SDS_IDX_RSVD_LAST);

	first_spread_hi_a: assert property (
		commit && pwrite && idx == `SDS_IDX_FIRST_SPREAD_HI |->
		##2 synth_cfg.first_spread_pct_code[14:8] == $past(pwdata[6:0], 2))
		else $error("first spread upper bits wrong");

	first_spread_lo_a: assert property (
		commit && pwrite && idx == `SDS_IDX_FIRST_SPREAD_LO |->
		##2 synth_cfg.first_spread_pct_code[7:0] == $past(pwdata[7:0], 2))
		else $error("first spread lower bits wrong");

	third_spread_a: assert property (
		commit && pwrite && idx == `SDS_IDX_THIRD_SPREAD_HI |->
		##2 synth_cfg.third_spread_pct_code[14:8] == $past(pwdata[6:0], 2))
		else $error("third spread upper bits wrong");

	third_ref_a: assert property (
		commit && pwrite && idx == `SDS_IDX_THIRD_DIV_HI |->
		##2 synth_cfg.third_ref_div == $past(pwdata[5:0], 2))
		else $error("third reference divider wrong");

	third_vco_a: assert property (
		commit && pwrite && idx == `SDS_IDX_THIRD_DIV_HI |->
		##2 synth_cfg.third_vco_div[9:8] == {$past(pwdata[6], 2), $past(pwdata[7], 2)})
		else $error("third vco divider top bits wrong");

	strap_load_a: assert property (
		s_q.phase == ST_LOAD |=> synth_cfg.third_ref_div == rom_ref($past(s_q.fs_sync))
		&& synth_cfg.third_vco_div == rom_vco($past(s_q.fs_sync)))
		else $error("strap table not loaded");

	override_en_a: assert property (
		commit && pwrite && idx == `SDS_IDX_OVERRIDE_EN |->
		##2 synth_cfg.cpu_override_en == $past(pwdata[1], 2)
		&& synth_cfg.serial_ref_override_en == $past(pwdata[0], 2))
		else $error("override enables wrong");

	cpu_div_a: assert property (
		commit && pwrite && idx == `SDS_IDX_CPU_DIV_HI |->
		##2 synth_cfg.cpu_ref_div == $past(pwdata[5:0], 2)
		&& synth_cfg.cpu_vco_div[8] == $past(pwdata[7], 2))
		else $error("cpu override dividers wrong");

	storage_pm_a: assert property (
		commit && pwrite && idx == `SDS_IDX_SPECIAL_POWER |->
		##2 synth_cfg.storage_link_synth_pm == $past(pwdata[1], 2))
		else $error("storage synthesizer power bit wrong");

	xtal_keep_a: assert property (
		s_q.phase == ST_SYNC_A |-> synth_cfg.crystal_powerdown_keepalive)
		else $error("crystal keep-alive not set after reset");

	rsvd_read_a: assert property (
		commit && !pwrite && rsvd_idx |-> prdata == 32'h00000000 && !pslverr)
		else $error("reserved byte read not zero");

	rsvd_write_a: assert property (
		commit && pwrite && rsvd_idx |=> $stable(s_q.bank))
		else $error("reserved byte write changed a register");

	no_mix_a: assert property (
		!$stable(synth_cfg) |-> $past(s_q.apply) || $past(s_q.phase == ST_LOAD))
		else $error("settings changed outside a whole write");

	third_spread_lo_a: assert property (
		commit && pwrite && idx == `SDS_IDX_THIRD_SPREAD_LO |->
		##2 synth_cfg.third_spread_pct_code[7:0] == $past(pwdata[7:0], 2))
		else $error("third spread lower bits wrong");

	cpu_vco_lo_a: assert property (
		commit && pwrite && idx == `SDS_IDX_CPU_VCO_LO |->
		##2 synth_cfg.cpu_vco_div[7:0] == $past(pwdata[7:0], 2))
		else $error("cpu vco divider low bits wrong");

	keep_write_a: assert property (
		commit && pwrite && idx == `SDS_IDX_SPECIAL_POWER |->
		##2 synth_cfg.crystal_powerdown_keepalive == $past(pwdata[0], 2))
		else $error("crystal keep-alive bit wrong");

	bus_stall_a: assert property (
		s_q.phase != ST_RUN |=> !pready)
		else $error("bus answered before strap load");

	write_cov: cover property (commit && pwrite && idx == `SDS_IDX_THIRD_DIV_HI);
	read_cov: cover property (commit && !pwrite && idx == `SDS_IDX_SPECIAL_POWER);
	rsvd_cov: cover property (commit && rsvd_idx);
	stall_cov: cover property (psel && s_q.phase != ST_RUN);

endmodule

// ### dv/sds_regs_tb.sv
`timescale 1ns/1ps
`include "sds_map.svh"

module sds_regs_tb;
	import sds_pkg::*;

	// ************************************************************
	// Bench signals and strap table
	// ************************************************************

	// Every row differs, so a wrong row pick shows up at once.
	localparam logic [47:0] TB_REF = {6'h3f, 6'h05, 6'h11, 6'h22, 6'h0e, 6'h2d, 6'h19, 6'h01};
	localparam logic [79:0] TB_VCO = {10'h3ff, 10'h155, 10'h2aa, 10'h100,
		10'h0c8, 10'h201, 10'h07f, 10'h1e3};

	logic           pclk;
	logic           presetn;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [7:0]     paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic [2:0]     fs_sel;
	sds_synth_cfg_t synth_cfg;
	logic [31:0]    rd_val;
	logic           rd_err;
	int             error_cnt;
	int             comparisons;
	logic [5:0]     idx_tab [10] = '{6'd15, 6'd16, 6'd17, 6'd18, 6'd19, 6'd20, 6'd21, 6'd22,
		6'd23, 6'd63};
	logic [7:0]     dat_tab [10] = '{8'ha5, 8'hff, 8'hab, 8'h5c, 8'h33, 8'h81, 8'h02, 8'h47,
		8'h9e, 8'h02};

	sds_regs #(
		.ROM_REF_DIV        (TB_REF),
		.ROM_VCO_DIV        (TB_VCO),
		.STORAGE_PM_DEFAULT (1'b0)
	) dut (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.fs_sel    (fs_sel),
		.synth_cfg (synth_cfg)
	);

	// Free-running 50 MHz clock.
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// ************************************************************
	// Bus and checking tasks
	// ************************************************************

	// Counts every compare; four-state inequality so an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; upper write bits carry junk that the block must ignore.
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h5a5a5a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// Ready is looked at on each rising edge; data is taken at the one where it is high.
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			error_cnt++;
		end
		rd_val = prdata;
		rd_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare both data and response.
	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp, input logic eerr);
		xfer(1'b0, idx, 8'h00);
		chk(rd_val, exp);
		chk(rd_err, eerr);
	endtask

	// Asynchronous reset held for 8 cycles with straps steady; no margin after it,
	// so the first request must wait out the strap load.
	task automatic do_reset(input logic [2:0] fs);
		presetn <= 1'b0;
		fs_sel  <= fs;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Start-up state must come from the strapped table row.
	task automatic chk_straps(input int r);
		logic [5:0] rf;
		logic [9:0] vc;
		rf = TB_REF[6*r +: 6];
		vc = TB_VCO[10*r +: 10];
		rdchk(6'd17, {vc[8], vc[9], rf}, 1'b0);
		rdchk(6'd18, vc[7:0], 1'b0);
		rdchk(6'd22, {vc[8], vc[9], rf}, 1'b0);
		rdchk(6'd23, vc[7:0], 1'b0);
		rdchk(6'd21, 8'h00, 1'b0);
		rdchk(6'd63, 8'h01, 1'b0);
		rdchk(6'd16, 8'h00, 1'b0);
		@(negedge pclk);
		chk(synth_cfg.third_ref_div, rf);
		chk(synth_cfg.third_vco_div, vc);
		chk(synth_cfg.cpu_ref_div, rf);
		chk(synth_cfg.cpu_vco_div, vc);
		chk({synth_cfg.cpu_override_en, synth_cfg.serial_ref_override_en}, 2'b00);
		chk({synth_cfg.storage_link_synth_pm, synth_cfg.crystal_powerdown_keepalive}, 2'b01);
	endtask

	task automatic conclude;
		$display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************

	// Main sequence: start-up, field mapping, reserved space, second reset.
	initial begin
		presetn     = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h0;
		fs_sel      = 3'd3;
		error_cnt   = 0;
		comparisons = 0;
		do_reset(3'd3);
		chk_straps(3);
		for (int i = 0; i < 10; i++) begin
			xfer(1'b1, idx_tab[i], dat_tab[i]);
		end
		for (int i = 0; i < 10; i++) begin
			rdchk(idx_tab[i], {24'h0, dat_tab[i]}, 1'b0);
		end
		chk(synth_cfg.first_spread_pct_code, 15'h7fa5);
		chk(synth_cfg.third_ref_div, 6'h2b);
		chk(synth_cfg.third_vco_div, 10'h15c);
		chk(synth_cfg.third_spread_pct_code, 15'h0133);
		chk({synth_cfg.cpu_override_en, synth_cfg.serial_ref_override_en}, 2'b10);
		chk(synth_cfg.cpu_ref_div, 6'h07);
		chk(synth_cfg.cpu_vco_div, 10'h29e);
		chk({synth_cfg.storage_link_synth_pm, synth_cfg.crystal_powerdown_keepalive}, 2'b10);
		// The settings hold their old value in the cycle after the commit, then follow.
		xfer(1'b1, 6'd21, 8'h01);
		@(negedge pclk);
		chk({synth_cfg.cpu_override_en, synth_cfg.serial_ref_override_en}, 2'b10);
		@(negedge pclk);
		chk({synth_cfg.cpu_override_en, synth_cfg.serial_ref_override_en}, 2'b01);
		// Reserved bytes swallow writes; unmapped ones answer with an error.
		xfer(1'b1, 6'd24, 8'hff);
		xfer(1'b1, 6'd62, 8'hff);
		xfer(1'b1, 6'd0, 8'hff);
		rdchk(6'd24, 32'h0, 1'b0);
		rdchk(6'd62, 32'h0, 1'b0);
		rdchk(6'd0, 32'h0, 1'b1);
		rdchk(6'd23, 32'h9e, 1'b0);
		// A reset in mid-run must bring back the defaults from a new strap row.
		do_reset(3'd5);
		chk_straps(5);
		conclude();
	end

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		conclude();
	end

endmodule
